// ===== rtl/crf_cfg.svh
// Constants for the command/reply framer
// Summary of operation
// [RULE_01] Host commands, device only answers each one
// [RULE_02] Reply sent only after execution completes; a bad-sum reply goes out from CHECK with no execution
// [RULE_03] Host waits for full reply first
// [RULE_04] Device never transmits unsolicited data
// [RULE_05] Line driven only while sending reply
// [RULE_06] Core: command, type, bank, value MSB first
// [RULE_07] Serial adds address and checksum: nine bytes
// [RULE_08] Command checksum: 8-bit sum of eight bytes
// [RULE_09] CAN command has no address or checksum
// [RULE_10] Exactly one reply per accepted command
// [RULE_11] Serial reply: raddr, maddr, status, cmd, value, sum
// [RULE_12] Reply checksum: 8-bit sum of others
// [RULE_13] CAN reply drops address and checksum bytes
// [RULE_14] Status 100 ok, 1 bad checksum
// [RULE_15] Foreign-address serial packets get no reply
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH
// Packet lengths in bytes
`define CRF_SER_CMD_LEN 4'h9
`define CRF_CAN_CMD_LEN 4'h7
`define CRF_SER_REP_LEN 4'h9
`define CRF_CAN_REP_LEN 4'h6
// Byte positions inside a received packet
`define CRF_POS_ADDR 4'h0
`define CRF_POS_SUM 4'h8
`define CRF_SER_BASE 4'h1
`define CRF_CAN_BASE 4'h0
// Status codes
`define CRF_ST_OK 8'h64
`define CRF_ST_BADSUM 8'h01
// Byte width and buffer depth
`define CRF_BYTE_W 8
`define CRF_FIFO_DEPTH 8
`endif

// ===== rtl/crf_pkg.sv
// Types shared by the framer modules
package crf_pkg;
  typedef enum logic [1:0] {
    ST_COLLECT,
    ST_CHECK,
    ST_EXEC,
    ST_REPLY
  } crf_state_t;
endpackage

// ===== rtl/crf_fifo.sv
// Byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module crf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full;
  logic empty;

  ////////////////////////////////////////////////////////////////////
  // Extra pointer bit separates full from empty
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_r[AW-1:0]];

  // Storage write, no reset needed for data
  always_ff @(posedge mclk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  property p_fifo_full_stalls;
    @(posedge mclk) disable iff (!rst_n)
    full |-> !in_ready ##1 (wr_ptr_r == $past(wr_ptr_r));
  endproperty
  a_fifo_full_stalls: assert property (p_fifo_full_stalls) else $error("fifo write while full");
endmodule
`default_nettype wire

// ===== rtl/crf_framer.sv
// Command framer, checker and reply builder
`timescale 1ns/1ps
`default_nettype none
`include "crf_cfg.svh"
module crf_framer #(
  parameter int FIFO_DEPTH = `CRF_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Configuration levels
  input wire logic can_mode,
  input wire logic [7:0] module_addr,
  input wire logic [7:0] reply_addr,
  // Received byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Command to executor
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_type,
  output logic [7:0] cmd_bank,
  output logic [31:0] cmd_value,
  // Executor result
  input wire logic exec_done,
  input wire logic [7:0] exec_status,
  input wire logic [31:0] exec_value,
  // Reply byte stream
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic tx_oe_n
);
  crf_pkg::crf_state_t state_r;
  logic fb_valid;
  logic [7:0] fb_data;
  logic fb_ready;
  logic [7:0] pkt_r [9];
  logic [3:0] rx_idx_r;
  logic [3:0] rx_len;
  logic [3:0] base;
  logic [7:0] sum_calc;
  logic addr_ok;
  logic sum_ok;
  logic load_rep;
  logic [7:0] st_sel;
  logic [31:0] val_sel;
  logic [7:0] code_sel;
  logic [7:0] rep_build [9];
  logic [7:0] rep_sum;
  logic [7:0] rep_r [9];
  logic [3:0] tx_left_r;
  logic tx_fire;

  ////////////////////////////////////////////////////////////////////
  // Input buffer; takes up to FIFO_DEPTH bytes while a command is processed, then stalls the sender
  crf_fifo #(
    .WIDTH(`CRF_BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out_valid(fb_valid),
    .out_data(fb_data),
    .out_ready(fb_ready)
  );

  // Bytes drained only while collecting a packet
  assign fb_ready = (state_r == crf_pkg::ST_COLLECT);
  assign rx_len = can_mode ? `CRF_CAN_CMD_LEN : `CRF_SER_CMD_LEN; // RULE_07
  assign base = can_mode ? `CRF_CAN_BASE : `CRF_SER_BASE; // RULE_09

  ////////////////////////////////////////////////////////////////////
  // Packet collection, fixed length per link type
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_idx_r <= 4'h0;
      for (int i = 0; i < 9; i++) begin
        pkt_r[i] <= 8'h00;
      end
    end else if (fb_valid && fb_ready) begin
      pkt_r[rx_idx_r] <= fb_data; // RULE_06
      rx_idx_r <= (rx_idx_r == rx_len - 4'h1) ? 4'h0 : rx_idx_r + 4'h1;
    end
  end

  // Checksum over the eight bytes before the last one
  always_comb begin
    sum_calc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      sum_calc = sum_calc + pkt_r[i]; // RULE_08
    end
  end
  // CAN has its own CRC, so address and sum always pass there
  assign sum_ok = can_mode || (sum_calc == pkt_r[`CRF_POS_SUM]); // RULE_09
  assign addr_ok = can_mode || (pkt_r[`CRF_POS_ADDR] == module_addr); // RULE_15

  ////////////////////////////////////////////////////////////////////
  // Sequencer: collect, check, execute, reply
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= crf_pkg::ST_COLLECT;
    end else begin
      case (state_r)
        crf_pkg::ST_COLLECT: begin
          if (fb_valid && rx_idx_r == rx_len - 4'h1) begin
            state_r <= crf_pkg::ST_CHECK;
          end
        end
        crf_pkg::ST_CHECK: begin
          if (!addr_ok) begin
            state_r <= crf_pkg::ST_COLLECT; // RULE_15
          end else if (!sum_ok) begin
            state_r <= crf_pkg::ST_REPLY; // RULE_14
          end else begin
            state_r <= crf_pkg::ST_EXEC; // RULE_01
          end
        end
        crf_pkg::ST_EXEC: begin
          if (exec_done) begin
            state_r <= crf_pkg::ST_REPLY; // RULE_02
          end
        end
        crf_pkg::ST_REPLY: begin
          if (tx_fire && tx_left_r == 4'h1) begin
            state_r <= crf_pkg::ST_COLLECT; // RULE_10
          end
        end
        default: begin
          state_r <= crf_pkg::ST_COLLECT;
        end
      endcase
    end
  end

  // Command fields latched once the packet is complete
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_code <= 8'h00;
      cmd_type <= 8'h00;
      cmd_bank <= 8'h00;
      cmd_value <= 32'h0000_0000;
    end else if (state_r == crf_pkg::ST_CHECK) begin
      cmd_code <= pkt_r[base];
      cmd_type <= pkt_r[base + 4'h1];
      cmd_bank <= pkt_r[base + 4'h2];
      cmd_value <= {pkt_r[base + 4'h3], pkt_r[base + 4'h4],
                    pkt_r[base + 4'h5], pkt_r[base + 4'h6]}; // RULE_06
    end
  end

  // Held until the executor reports completion
  assign cmd_valid = (state_r == crf_pkg::ST_EXEC); // RULE_02

  ////////////////////////////////////////////////////////////////////
  // Reply assembly
  assign load_rep = (state_r == crf_pkg::ST_CHECK && addr_ok && !sum_ok) ||
                    (state_r == crf_pkg::ST_EXEC && exec_done);
  assign st_sel = (state_r == crf_pkg::ST_CHECK) ? `CRF_ST_BADSUM : exec_status; // RULE_14
  assign val_sel = (state_r == crf_pkg::ST_CHECK) ? 32'h0000_0000 : exec_value;
  // Bad-sum reply is built in CHECK, before the command latch has updated
  assign code_sel = (state_r == crf_pkg::ST_CHECK) ? pkt_r[base] : cmd_code; // RULE_11

  // Serial layout first; CAN layout drops both addresses and the sum
  always_comb begin
    rep_sum = reply_addr + module_addr + st_sel + code_sel +
              val_sel[31:24] + val_sel[23:16] + val_sel[15:8] + val_sel[7:0]; // RULE_12
    if (can_mode) begin
      rep_build = '{st_sel, code_sel, val_sel[31:24], val_sel[23:16],
                    val_sel[15:8], val_sel[7:0], 8'h00, 8'h00, 8'h00}; // RULE_13
    end else begin
      rep_build = '{reply_addr, module_addr, st_sel, code_sel, val_sel[31:24],
                    val_sel[23:16], val_sel[15:8], val_sel[7:0], rep_sum}; // RULE_11
    end
  end

  // Shift register out; head byte is the line data
  assign tx_fire = tx_valid && tx_ready;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_left_r <= 4'h0;
      for (int i = 0; i < 9; i++) begin
        rep_r[i] <= 8'h00;
      end
    end else if (load_rep) begin
      rep_r <= rep_build;
      tx_left_r <= can_mode ? `CRF_CAN_REP_LEN : `CRF_SER_REP_LEN; // RULE_10
    end else if (tx_fire) begin
      for (int i = 0; i < 8; i++) begin
        rep_r[i] <= rep_r[i + 1];
      end
      rep_r[8] <= 8'h00;
      tx_left_r <= tx_left_r - 4'h1;
    end
  end

  // Transmit only inside a reply; line released otherwise
  assign tx_data = rep_r[0];
  assign tx_valid = (state_r == crf_pkg::ST_REPLY); // RULE_04
  assign tx_oe_n = !(state_r == crf_pkg::ST_REPLY); // RULE_05

  ////////////////////////////////////////////////////////////////////
  // Checks
  logic [3:0] sent_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sent_r <= 4'h0;
    end else if (state_r != crf_pkg::ST_REPLY) begin
      sent_r <= 4'h0;
    end else if (tx_fire) begin
      sent_r <= sent_r + 4'h1;
    end
  end

  property p_tx_only_reply;
    @(posedge mclk) disable iff (!rst_n)
    tx_valid |-> state_r == crf_pkg::ST_REPLY && $past(state_r) != crf_pkg::ST_COLLECT;
  endproperty
  a_tx_only_reply: assert property (p_tx_only_reply) else $error("unsolicited tx"); // RULE_04

  property p_oe_while_reply;
    @(posedge mclk) disable iff (!rst_n)
    !tx_oe_n |-> tx_valid;
  endproperty
  a_oe_while_reply: assert property (p_oe_while_reply) else $error("line driven idle"); // RULE_05

  property p_reply_after_exec;
    @(posedge mclk) disable iff (!rst_n)
    $rose(tx_valid) |-> $past(exec_done && cmd_valid) || $past(state_r) == crf_pkg::ST_CHECK;
  endproperty
  a_reply_after_exec: assert property (p_reply_after_exec) else $error("early reply"); // RULE_02

  property p_cmd_held;
    @(posedge mclk) disable iff (!rst_n)
    cmd_valid && !exec_done |=> cmd_valid && $stable(cmd_code) && $stable(cmd_value);
  endproperty
  a_cmd_held: assert property (p_cmd_held) else $error("command dropped"); // RULE_02

  property p_foreign_ignored;
    @(posedge mclk) disable iff (!rst_n)
    state_r == crf_pkg::ST_CHECK && !can_mode && pkt_r[`CRF_POS_ADDR] != module_addr
      |=> state_r == crf_pkg::ST_COLLECT ##1 !tx_valid;
  endproperty
  a_foreign_ignored: assert property (p_foreign_ignored) else $error("foreign reply"); // RULE_15

  property p_badsum_status;
    @(posedge mclk) disable iff (!rst_n)
    state_r == crf_pkg::ST_CHECK && !can_mode && pkt_r[`CRF_POS_ADDR] == module_addr &&
      sum_calc != pkt_r[`CRF_POS_SUM] |=> tx_valid ##0 tx_data == reply_addr ##0
      rep_r[2] == `CRF_ST_BADSUM;
  endproperty
  a_badsum_status: assert property (p_badsum_status) else $error("bad sum status"); // RULE_14

  property p_ser_head;
    @(posedge mclk) disable iff (!rst_n)
    $rose(tx_valid) && !can_mode |-> tx_data == reply_addr && rep_r[1] == module_addr &&
      rep_r[8] == rep_r[0] + rep_r[1] + rep_r[2] + rep_r[3] + rep_r[4] + rep_r[5] +
      rep_r[6] + rep_r[7];
  endproperty
  a_ser_head: assert property (p_ser_head) else $error("serial reply layout"); // RULE_11

  property p_can_head;
    @(posedge mclk) disable iff (!rst_n)
    $rose(tx_valid) && can_mode && $past(exec_done) |-> tx_data == $past(exec_status) &&
      rep_r[1] == cmd_code;
  endproperty
  a_can_head: assert property (p_can_head) else $error("can reply layout"); // RULE_13

  property p_reply_length;
    @(posedge mclk) disable iff (!rst_n)
    $fell(tx_valid) |-> $past(sent_r) ==
      (can_mode ? `CRF_CAN_REP_LEN - 4'h1 : `CRF_SER_REP_LEN - 4'h1);
  endproperty
  a_reply_length: assert property (p_reply_length) else $error("reply length"); // RULE_10

  // A good serial packet addressed here always reaches the executor
  property p_sum_exec;
    @(posedge mclk) disable iff (!rst_n)
    state_r == crf_pkg::ST_CHECK && !can_mode && pkt_r[`CRF_POS_ADDR] == module_addr &&
      sum_calc == pkt_r[`CRF_POS_SUM] |=> cmd_valid;
  endproperty
  a_sum_exec: assert property (p_sum_exec) else $error("good sum not run"); // RULE_08

  // Executor completion opens the reply on the very next cycle
  property p_one_reply;
    @(posedge mclk) disable iff (!rst_n)
    cmd_valid && exec_done |=> tx_valid && !tx_oe_n;
  endproperty
  a_one_reply: assert property (p_one_reply) else $error("missing reply"); // RULE_10

  // Slave only: idle never jumps straight into a reply
  property p_slave_only;
    @(posedge mclk) disable iff (!rst_n)
    state_r == crf_pkg::ST_COLLECT |=> !tx_valid;
  endproperty
  a_slave_only: assert property (p_slave_only) else $error("reply without command"); // RULE_01

  c_ok_reply: cover property (@(posedge mclk) disable iff (!rst_n)
    $rose(tx_valid) && !can_mode && rep_r[2] == `CRF_ST_OK);
  c_badsum: cover property (@(posedge mclk) disable iff (!rst_n)
    $rose(tx_valid) && !can_mode && rep_r[2] == `CRF_ST_BADSUM);
  c_ignored: cover property (@(posedge mclk) disable iff (!rst_n)
    state_r == crf_pkg::ST_CHECK && !addr_ok);
  c_can_reply: cover property (@(posedge mclk) disable iff (!rst_n)
    $fell(tx_valid) && can_mode);
endmodule
`default_nettype wire

// ===== testbench/crf_host_model.sv
// Host bus master model: offers command bytes and collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module crf_host_model (
  // Clock
  input wire logic mclk,
  // Command byte stream
  output var logic rx_valid,
  output var logic [7:0] rx_data,
  input wire logic rx_ready,
  // Reply byte stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output var logic tx_ready
);
  logic [7:0] rep_q[$];
  logic [7:0] dat;
  logic hit = 1'b0;
  int seed = 32'hADAB7C87;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Random stalls on the reply side; a byte counts where valid meets ready
  always @(negedge mclk) begin
    if (hit) rep_q.push_back(dat);
    tx_ready = ({$random(seed)} % 3) != 0;
    #1 hit = (tx_valid === 1'b1) && tx_ready;
    dat = tx_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Whole packet in order, each byte held until taken; caller waits for reply
  task automatic send_pkt(input logic [7:0] pkt[$]);
    logic rdy;
    foreach (pkt[i]) begin
      rx_valid = 1'b1;
      rx_data = pkt[i];
      do begin
        #1 rdy = rx_ready;
        @(negedge mclk);
      end while (rdy !== 1'b1);
    end
    // Released data shows a changed value, not the last byte
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Testbench: framer against the host model and a behavioural reference
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, rst_n, can_mode, rx_valid, rx_ready, cmd_valid, exec_done;
  logic tx_valid, tx_ready, tx_oe_n, tx_seen;
  logic [7:0] module_addr, reply_addr, rx_data, cmd_code, cmd_type, cmd_bank;
  logic [7:0] exec_status, tx_data, e_code, e_type, e_bank, e_st;
  logic [31:0] cmd_value, exec_value, e_val, e_rv;
  int fails = 0;
  int checks_done = 0;
  int cmd_cnt = 0;
  int seed = 32'hADAB7C87;
  logic [7:0] st_tab[4] = '{8'h64, 8'h02, 8'h03, 8'h04};

  crf_framer #(.FIFO_DEPTH(8)) crf_framer_i (.mclk(mclk), .rst_n(rst_n),
    .can_mode(can_mode), .module_addr(module_addr), .reply_addr(reply_addr),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_type(cmd_type),
    .cmd_bank(cmd_bank), .cmd_value(cmd_value), .exec_done(exec_done),
    .exec_status(exec_status), .exec_value(exec_value), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .tx_oe_n(tx_oe_n));
  crf_host_model crf_host_model_i (.mclk(mclk), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s at %0t: got %h want %h", what, $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Line monitor: drive enable tracks the reply, silence while executing
  always @(negedge mclk) if (rst_n) begin
    if (tx_valid === 1'b1) tx_seen = 1'b1;
    if (tx_oe_n !== ~tx_valid) check(tx_oe_n, {~tx_valid}, "line enable");
    if (cmd_valid === 1'b1 && tx_valid !== 1'b0) check(tx_valid, 0, "early reply");
  end

  // Executor stand-in; random latency so the reply must wait for it
  initial begin
    exec_done = 1'b0;
    exec_status = 8'h00;
    exec_value = 32'h0;
    forever begin
      @(negedge mclk);
      if (cmd_valid === 1'b1) begin
        cmd_cnt++;
        check({cmd_code, cmd_type, cmd_bank}, {e_code, e_type, e_bank}, "fields");
        check(cmd_value, e_val, "value");
        repeat ({$random(seed)} % 4) @(negedge mclk);
        exec_done = 1'b1;
        exec_status = e_st;
        exec_value = e_rv;
        @(negedge mclk);
        exec_done = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One exchange: mode 0 good, 1 bad sum, 2 foreign address, 3 CAN
  task automatic run_cmd(input int mode, input int st);
    logic [7:0] pkt[$];
    logic [7:0] exp[$];
    logic [7:0] s;
    logic [31:0] r;
    int n;
    int c0;
    r = $random(seed);
    e_val = $random(seed);
    e_rv = $random(seed);
    {e_bank, e_type, e_code} = r[23:0];
    e_st = st_tab[st];
    can_mode = (mode == 3);
    pkt = {e_code, e_type, e_bank, e_val[31:24], e_val[23:16], e_val[15:8], e_val[7:0]};
    if (mode != 3) begin
      pkt.push_front(mode == 2 ? module_addr ^ 8'h01 : module_addr);
      s = 8'h00;
      foreach (pkt[i]) s += pkt[i];
      pkt.push_back(mode == 1 ? s + 8'h01 : s);
    end
    if (mode == 1) begin
      e_st = 8'h01;
      e_rv = 32'h0;
    end
    exp = {e_st, e_code, e_rv[31:24], e_rv[23:16], e_rv[15:8], e_rv[7:0]};
    if (mode != 3) begin
      exp.push_front(module_addr);
      exp.push_front(reply_addr);
      s = 8'h00;
      foreach (exp[i]) s += exp[i];
      exp.push_back(s);
    end
    c0 = cmd_cnt;
    tx_seen = 1'b0;
    crf_host_model_i.rep_q.delete();
    crf_host_model_i.send_pkt(pkt);
    n = 0;
    while (crf_host_model_i.rep_q.size() < exp.size() && n < 300) begin
      @(negedge mclk);
      n++;
    end
    if (mode == 2) begin
      check(tx_seen, 0, "foreign reply");
    end else begin
      // Extra cycles expose a surplus byte or an unsolicited restart
      repeat (4) @(negedge mclk);
      check(crf_host_model_i.rep_q.size(), exp.size(), "reply length");
      foreach (exp[i]) check(crf_host_model_i.rep_q[i], exp[i], "reply byte");
      check(tx_valid, 0, "idle after reply");
    end
    check(cmd_cnt - c0, (mode == 1 || mode == 2) ? 0 : 1, "exec count");
  endtask

  // Main sequence: all modes, every status code through the good path
  initial begin
    logic [31:0] r;
    rst_n = 1'b0;
    can_mode = 1'b0;
    module_addr = 8'h01;
    reply_addr = 8'h02;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    check(tx_oe_n, 1, "idle enable");
    check(rx_ready, 1, "idle ready");
    for (int k = 0; k < 16; k++) begin
      r = $random(seed);
      module_addr = r[7:0];
      reply_addr = r[15:8];
      run_cmd(k % 4, k / 4);
    end
    final_report();
  end

  // Watchdog: the whole run needs well under 200 us
  initial begin
    #200us;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
